// ===== core/dcp_port.sv
// Configuration port: serial link and parallel bus into a buffered control register
//
// Notes on behaviour
// - Chip select high releases both serial data pins.
// - Chip select high freezes a cycle mid-way; it resumes when low again.
// - Data pin always takes writes; drives reads unless input-only bit is set.
// - In single bidirectional pin mode the separate data output stays released.
// - Resync high aborts the cycle, resets the sequencer, keeps registers.
// - After resync the next byte is an instruction byte.
// - Rising update strobe copies the port buffer into active registers.
// - Data phase follows instruction byte without any clock gap.
// - Control bit 0 picks LSB-first order for every bit, instruction included.
// - A register's highest-numbered bit is its most significant serial bit.
// - All four function selects low chooses the parallel port.
// - Parallel port: eight address lines, width pin picks 8 or 16 data bits.
// - 16-bit mode: upper byte to addressed byte, lower byte one below.
// - Parallel port writes any byte in one strobe and reads every register.
// - Control byte 2 holds streaming enable and sine output enable.
// - Instruction bit 7 is read flag, bit 6 ignored, bits 5..0 address.
// - Write bits sampled on rising clock, read bits driven on falling.
// - Function select 0 high, 1 to 3 low chooses the serial port.
`timescale 1ns/10ps
`include "dcp_defines.svh"
module dcp_port (
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  function_select_pins,
	input  wire logic        width_select,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	input  wire logic        port_resync,
	input  wire logic        io_update,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [7:0]  par_addr,
	input  wire logic [15:0] par_data_in,
	output logic      [15:0] par_data_out,
	output logic             par_data_oe,
	output logic      [31:0] control_function_1,
	output logic             stream_enable,
	output logic             sine_output_enable
);
	// ****************************************
	// Pin sampling
	// ****************************************
	dcp_pkg::dcp_pins_t pin_raw;
	dcp_pkg::dcp_pins_t pin_s;
	logic [`DCP_PIN_WIDTH-1:0] sync_in;
	logic [`DCP_PIN_WIDTH-1:0] sync_out;

	// Synchroniser clears to zero; pins that idle high pass inverted, so reset shows
	// idle strobes and produces no false strobe edge or bus drive
	localparam dcp_pkg::dcp_pins_t PIN_IDLE = '{fsel: 4'h0, width16: 1'b0, sclk: 1'b0,
		cs_n: 1'b1, sdio: 1'b0, resync: 1'b0, io_update: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
		addr: 8'h00, data: 16'h0000};

	assign pin_raw = '{fsel: function_select_pins, width16: width_select, sclk: sclk,
		cs_n: cs_n, sdio: sdio_in, resync: port_resync, io_update: io_update,
		rd_n: rd_n, wr_n: wr_n, addr: par_addr, data: par_data_in};
	assign sync_in = pin_raw ^ PIN_IDLE;
	assign pin_s   = sync_out ^ PIN_IDLE;

	dcp_sync3 #(
		.W (`DCP_PIN_WIDTH)
	) u_sync (
		.clk        (clk),
		.ce         (ce),
		.sys_rst    (sys_rst),
		.pin_in     (sync_in),
		.stable_out (sync_out)
	);

	// ****************************************
	// State
	// ****************************************
	dcp_pkg::dcp_state_t state_ff;
	dcp_pkg::dcp_state_t nxt_state;
	logic [2:0]  icnt_ff, nxt_icnt;
	logic [4:0]  dcnt_ff, nxt_dcnt;
	logic        rw_ff, nxt_rw;
	logic [5:0]  addr_ff, nxt_addr;
	logic [7:0]  byte_ff, nxt_byte;
	logic [31:0] buf_ff, nxt_buf;
	logic [31:0] act_ff, nxt_act;
	logic        sbit_ff, nxt_sbit;
	logic [15:0] pdo_ff, nxt_pdo;
	logic        sclk_q_ff, wr_q_ff, upd_q_ff;

	logic ser_mode, par_mode, lsb_first, in_only;
	logic [7:0] addr_lo;
	logic sclk_rise, sclk_fall, wr_fall, upd_rise;

	assign ser_mode  = (pin_s.fsel == `DCP_SEL_SERIAL);
	assign par_mode  = (pin_s.fsel == `DCP_SEL_PARALLEL);
	assign lsb_first = act_ff[`DCP_BIT_LSB_FIRST];
	assign in_only   = act_ff[`DCP_BIT_SDIO_IN_ONLY];
	assign sclk_rise = pin_s.sclk & ~sclk_q_ff;
	assign sclk_fall = ~pin_s.sclk & sclk_q_ff;
	assign wr_fall   = ~pin_s.wr_n & wr_q_ff;
	assign upd_rise  = pin_s.io_update & ~upd_q_ff;
	assign addr_lo   = pin_s.addr - 8'h01;

	// Bit within a byte, and byte lane within the register, for the current order
	function automatic logic [2:0] bit_idx(input logic lsb, input logic [2:0] k);
		bit_idx = lsb ? k : 3'h7 - k;
	endfunction

	function automatic logic [1:0] lane_idx(input logic lsb, input logic [1:0] k);
		lane_idx = lsb ? k : 2'h3 - k;
	endfunction

	function automatic logic [7:0] rd_byte(input logic [31:0] r, input logic [7:0] a);
		rd_byte = (a < 8'h04) ? r[a[1:0]*8 +: 8] : 8'h00;
	endfunction

	always_comb
	begin
		nxt_state = state_ff;
		nxt_icnt  = icnt_ff;
		nxt_dcnt  = dcnt_ff;
		nxt_rw    = rw_ff;
		nxt_addr  = addr_ff;
		nxt_byte  = byte_ff;
		nxt_buf   = buf_ff;
		nxt_act   = act_ff;
		nxt_sbit  = sbit_ff;
		nxt_pdo   = pdo_ff;
		if (ser_mode)
		begin
			if (pin_s.resync)
			begin
				// Partial bytes are dropped; completed ones already sit in the buffer
				nxt_state = dcp_pkg::DCP_ST_INSTR;
				nxt_icnt  = 3'h0;
				nxt_dcnt  = 5'h00;
			end
			else if (!pin_s.cs_n)
			begin
				if (sclk_rise)
				begin
					case (state_ff)
						dcp_pkg::DCP_ST_INSTR:
						begin
							nxt_byte[bit_idx(lsb_first, icnt_ff)] = pin_s.sdio;
							nxt_icnt = icnt_ff + 3'h1;
							if (icnt_ff == `DCP_LAST_INSTR_BIT)
							begin
								nxt_rw    = nxt_byte[`DCP_INS_RW_BIT];
								nxt_addr  = nxt_byte[5:0];
								nxt_state = dcp_pkg::DCP_ST_DATA;
								nxt_dcnt  = 5'h00;
							end
						end
						dcp_pkg::DCP_ST_DATA:
						begin
							nxt_byte[bit_idx(lsb_first, dcnt_ff[2:0])] = pin_s.sdio;
							if (!rw_ff && dcnt_ff[2:0] == 3'h7 && addr_ff == `DCP_CTRL_OFFSET)
								nxt_buf[lane_idx(lsb_first, dcnt_ff[4:3])*8 +: 8] = nxt_byte;
							nxt_dcnt = dcnt_ff + 5'h01;
							if (dcnt_ff == `DCP_LAST_DATA_BIT)
								nxt_state = dcp_pkg::DCP_ST_INSTR;
						end
						default:
							nxt_state = dcp_pkg::DCP_ST_INSTR;
					endcase
				end
				if (sclk_fall && state_ff == dcp_pkg::DCP_ST_DATA && rw_ff)
					nxt_sbit = (addr_ff == `DCP_CTRL_OFFSET) &&
						act_ff[{lane_idx(lsb_first, dcnt_ff[4:3]), bit_idx(lsb_first, dcnt_ff[2:0])}];
			end
		end
		if (par_mode)
		begin
			if (wr_fall)
			begin
				if (pin_pkg_lane_ok(pin_s.addr))
					nxt_buf[pin_s.addr[1:0]*8 +: 8] = pin_s.width16 ? pin_s.data[15:8]
						: pin_s.data[7:0];
				if (pin_s.width16 && pin_s.addr != 8'h00 && pin_pkg_lane_ok(addr_lo))
					nxt_buf[addr_lo[1:0]*8 +: 8] = pin_s.data[7:0];
			end
			if (!pin_s.rd_n)
				nxt_pdo = pin_s.width16 ? {rd_byte(act_ff, pin_s.addr),
					rd_byte(act_ff, pin_s.addr - 8'h01)} : {8'h00, rd_byte(act_ff, pin_s.addr)};
		end
		if (upd_rise)
			nxt_act = nxt_buf;
	end

	function automatic logic pin_pkg_lane_ok(input logic [7:0] a);
		pin_pkg_lane_ok = (a < 8'h04);
	endfunction

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff  <= dcp_pkg::DCP_ST_INSTR;
			icnt_ff   <= 3'h0;
			dcnt_ff   <= 5'h00;
			rw_ff     <= 1'b0;
			addr_ff   <= 6'h00;
			byte_ff   <= 8'h00;
			buf_ff    <= `DCP_CTRL_RESET;
			act_ff    <= `DCP_CTRL_RESET;
			sbit_ff   <= 1'b0;
			pdo_ff    <= 16'h0000;
			sclk_q_ff <= 1'b0;
			wr_q_ff   <= 1'b1;
			upd_q_ff  <= 1'b0;
		end
		else if (ce)
		begin
			state_ff  <= nxt_state;
			icnt_ff   <= nxt_icnt;
			dcnt_ff   <= nxt_dcnt;
			rw_ff     <= nxt_rw;
			addr_ff   <= nxt_addr;
			byte_ff   <= nxt_byte;
			buf_ff    <= nxt_buf;
			act_ff    <= nxt_act;
			sbit_ff   <= nxt_sbit;
			pdo_ff    <= nxt_pdo;
			sclk_q_ff <= pin_s.sclk;
			wr_q_ff   <= pin_s.wr_n;
			upd_q_ff  <= pin_s.io_update;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic rd_drive;
	assign rd_drive           = ser_mode && !pin_s.cs_n && rw_ff &&
		state_ff == dcp_pkg::DCP_ST_DATA;
	assign sdio_out           = sbit_ff;
	assign sdio_oe            = rd_drive && !in_only;
	assign serial_data_out    = sbit_ff;
	assign serial_data_out_oe = rd_drive && in_only;
	assign par_data_out       = pdo_ff;
	assign par_data_oe        = par_mode && !pin_s.rd_n;
	assign control_function_1 = act_ff;
	assign stream_enable      = act_ff[`DCP_BIT_STREAM_EN];
	assign sine_output_enable = act_ff[`DCP_BIT_SINE_EN];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_CS_HIZ: assert property (pin_s.cs_n |-> !sdio_oe && !serial_data_out_oe)
		else $error("Serial data pins driven while chip select high");
	AST_SUSPEND: assert property (ce && pin_s.cs_n && !pin_s.resync && ser_mode |=> $stable(state_ff)
		&& $stable(dcnt_ff) && $stable(icnt_ff))
		else $error("Serial cycle advanced while chip select high");
	AST_SDO_BIDIR: assert property (!in_only |-> !serial_data_out_oe)
		else $error("Separate data output driven in bidirectional mode");
	AST_RESYNC: assert property (ce && ser_mode && pin_s.resync |=>
		state_ff == dcp_pkg::DCP_ST_INSTR && icnt_ff == 3'h0)
		else $error("Resync did not return to instruction phase");
	AST_RESYNC_KEEP: assert property (ce && pin_s.resync && !upd_rise && !par_mode |=>
		act_ff == $past(act_ff))
		else $error("Resync changed active register");
	AST_UPDATE: assert property (ce && upd_rise |=> act_ff == $past(nxt_buf))
		else $error("Update edge did not load active register");
	AST_NO_GAP: assert property (ce && ser_mode && !pin_s.resync && !pin_s.cs_n && sclk_rise
		&& state_ff == dcp_pkg::DCP_ST_INSTR && icnt_ff == 3'h7 |=>
		state_ff == dcp_pkg::DCP_ST_DATA && dcnt_ff == 5'h00)
		else $error("Data phase did not follow instruction byte");
	AST_PAR_WR8: assert property (ce && par_mode && wr_fall && !pin_s.width16 &&
		pin_s.addr == 8'h02 && !upd_rise |=> buf_ff[23:16] == $past(pin_s.data[7:0]))
		else $error("Parallel byte write lost");
	AST_SER_SEL: assert property (!ser_mode |-> !sdio_oe && !serial_data_out_oe)
		else $error("Serial pins driven outside serial mode");

	COV_SER_READ: cover property (sdio_oe ##1 sdio_oe);
	COV_SER_WRITE: cover property (state_ff == dcp_pkg::DCP_ST_DATA && !rw_ff && dcnt_ff == 5'h1f);
	COV_PAR_WR16: cover property (par_mode && wr_fall && pin_s.width16);
	COV_UPDATE: cover property (upd_rise);
endmodule

// ===== common/dcp_defines.svh
// Register offsets, field positions, reset values and mode codes of the config port
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH
`define DCP_CTRL_OFFSET      6'h00
`define DCP_CTRL_RESET       32'h0000_0008
`define DCP_BIT_LSB_FIRST    0
`define DCP_BIT_SDIO_IN_ONLY 1
`define DCP_BIT_SINE_EN      16
`define DCP_BIT_STREAM_EN    17
`define DCP_INS_RW_BIT       7
`define DCP_SEL_SERIAL       4'h1
`define DCP_SEL_PARALLEL     4'h0
`define DCP_CTRL_BYTES       3'h4
`define DCP_LAST_DATA_BIT    5'h1f
`define DCP_LAST_INSTR_BIT   3'h7
`define DCP_PIN_WIDTH        36
`endif

// ===== common/dcp_pkg.sv
// Types shared by the configuration port modules
package dcp_pkg;
	typedef enum logic [1:0] {
		DCP_ST_INSTR = 2'b01,
		DCP_ST_DATA  = 2'b10
	} dcp_state_t;

	typedef struct packed {
		logic [3:0]  fsel;
		logic        width16;
		logic        sclk;
		logic        cs_n;
		logic        sdio;
		logic        resync;
		logic        io_update;
		logic        rd_n;
		logic        wr_n;
		logic [7:0]  addr;
		logic [15:0] data;
	} dcp_pins_t;
endpackage

// ===== core/dcp_sync3.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/10ps
module dcp_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         ce,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] stable_out
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			assign nxt_out[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : out_ff[gi];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end
		else if (ce)
		begin
			s1_ff  <= pin_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign stable_out = out_ff;
endmodule

// ===== dv/dcp_host_model.sv
// Host-side serial master model for the configuration port link
`timescale 1ns/10ps
module dcp_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio_in,
	output logic      port_resync,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic serial_data_out,
	input  wire logic serial_data_out_oe,
	output logic      oe_idle,
	output logic      sep_seen
);
	logic       host_oe = 1'b0;
	logic       host_bit = 1'b0;
	logic       filler = 1'b0;
	logic       cs_keep = 1'b0;
	logic       idle_bad = 1'b0;
	logic       sep_hit = 1'b0;
	logic [3:0] hi_cnt = 4'h0;
	assign oe_idle  = idle_bad;
	assign sep_seen = sep_hit;
	initial
	begin
		{sclk, cs_n, port_resync} = 3'h2;
	end
	// ********************************
	// Line monitor
	// ********************************
	// A released line has no pull, so it toggles instead of keeping the last bit
	always @(posedge clk)
	begin
		filler <= ~filler;
		hi_cnt <= !cs_n ? 4'h0 : (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1);
		// Synchronisers lag the pin, so judge only once select has been high a while
		if (hi_cnt > 4'h6 && (sdio_oe || serial_data_out_oe))
			idle_bad <= 1'b1;
		if (serial_data_out_oe)
			sep_hit <= 1'b1;
	end
	assign sdio_in = host_oe ? host_bit : (sdio_oe ? sdio_out : filler);
	task automatic half();
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic frame(input logic [7:0] ins, input logic [31:0] wd, input logic lsb,
			input int hold_at, input int cut_at, output logic [31:0] rd);
		int k;
		rd = 32'h0;
		cs_n = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			if (i == cut_at)
			begin
				port_resync = 1'b1;
				half();
				port_resync = 1'b0;
				break;
			end
			if (i == hold_at)
			begin
				// Let the last falling edge land before select goes high
				half();
				cs_n = 1'b1;
				half();
				sclk = 1'b1;
				half();
				sclk = 1'b0;
				half();
				cs_n = 1'b0;
			end
			k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
			host_oe = (i < 8) || !ins[7];
			host_bit = (i < 8) ? ins[k] : wd[k];
			half();
			if (i >= 8)
				rd[k] = sdio_oe ? sdio_out : (serial_data_out_oe ? serial_data_out : filler);
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
		half();
		cs_n = ~cs_keep;
		host_oe = 1'b0;
	endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the configuration port
`timescale 1ns/10ps
module testbench;
	typedef struct packed {logic par; logic [31:0] val;} dcp_row_t;
	logic        clk, sys_rst, width_select, sclk, cs_n, sdio_in, sdio_out, sdio_oe;
	logic        sep_out, sep_oe, port_resync, io_update, rd_n, wr_n, par_data_oe;
	logic        stream_enable, sine_output_enable, oe_idle, sep_seen;
	logic [3:0]  fsel;
	logic [7:0]  par_addr;
	logic [15:0] par_data_in, par_data_out, pd;
	logic [31:0] cf1, rd, v, cur;
	int          errors = 0;
	int          n_checks = 0;
	dcp_row_t    rows [4] = '{'{1'b0, 32'h0003_0000}, '{1'b1, 32'h5a02_a5f0},
		'{1'b0, 32'hc301_3c04}, '{1'b1, 32'h0000_0008}};
	dcp_port dcp_port_i (.clk, .ce(1'b1), .sys_rst, .function_select_pins(fsel), .width_select,
		.sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .serial_data_out(sep_out),
		.serial_data_out_oe(sep_oe), .port_resync, .io_update, .rd_n, .wr_n, .par_addr,
		.par_data_in, .par_data_out, .par_data_oe, .control_function_1(cf1), .stream_enable,
		.sine_output_enable);
	dcp_host_model dcp_host_model_i (.clk, .sclk, .cs_n, .sdio_in, .port_resync, .sdio_out,
		.sdio_oe, .serial_data_out(sep_out), .serial_data_out_oe(sep_oe), .oe_idle, .sep_seen);
	// ********************************
	// Tasks
	// ********************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic mode(input logic [3:0] m);
		fsel = m;
		tick(8);
	endtask
	task automatic ser(input logic [7:0] ins, input logic [31:0] wd, input logic lsb,
			input int hold, input int cut);
		mode(4'h1);
		dcp_host_model_i.frame(ins, wd, lsb, hold, cut, rd);
	endtask
	task automatic pwr(input logic w16, input logic [7:0] a, input logic [15:0] d);
		mode(4'h0);
		{width_select, par_addr, par_data_in} = {w16, a, d};
		tick(6);
		wr_n = 1'b0;
		tick(8);
		wr_n = 1'b1;
		tick(8);
	endtask
	task automatic prd(input logic w16, input logic [7:0] a);
		mode(4'h0);
		{width_select, par_addr} = {w16, a};
		tick(6);
		rd_n = 1'b0;
		tick(8);
		pd = par_data_out;
		chk("par_data_oe", 32'h1, {31'h0, par_data_oe});
		rd_n = 1'b1;
		tick(8);
	endtask
	task automatic upd();
		io_update = 1'b1;
		tick(8);
		io_update = 1'b0;
		tick(8);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#400000;
		errors++;
		wrap_up();
	end
	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		{sys_rst, fsel, width_select, io_update, rd_n, wr_n} = 9'h123;
		{par_addr, par_data_in} = 24'h0;
		cur = 32'h0000_0008;
		tick(2);
		sys_rst = 1'b0;
		tick(6);
		chk("reset cf1", cur, cf1);
		chk("reset oe", 32'h0, {29'h0, sdio_oe, sep_oe, par_data_oe});
		foreach (rows[r])
		begin
			v = rows[r].val;
			if (rows[r].par)
				for (int b = 0; b < 4; b++)
					pwr(1'b0, 8'(b), {8'h00, v[8*b +: 8]});
			else
				ser(8'h40, v, 1'b0, -1, -1);
			chk("before update", cur, cf1);
			upd();
			chk("cf1", v, cf1);
			chk("enables", {30'h0, v[17:16]}, {30'h0, stream_enable, sine_output_enable});
			ser(8'hc0, 32'h0, 1'b0, -1, -1);
			chk("serial read", v, rd);
			prd(1'b0, 8'h02);
			chk("par read", {24'h0, v[23:16]}, {24'h0, pd[7:0]});
			cur = v;
		end
		chk("sep in bidir", 32'h0, {31'h0, sep_seen});
		ser(8'h00, 32'h1234_5678, 1'b0, 25, -1);
		upd();
		chk("paused write", 32'h1234_5678, cf1);
		ser(8'h80, 32'h0, 1'b0, 30, -1);
		chk("paused read", 32'h1234_5678, rd);
		ser(8'h00, 32'hffff_ffff, 1'b0, -1, 21);
		chk("after abort", 32'h1234_5678, cf1);
		ser(8'h00, 32'h0001_0009, 1'b0, -1, -1);
		upd();
		chk("after resync", 32'h0001_0009, cf1);
		ser(8'h00, 32'h00a5_3c19, 1'b1, -1, -1);
		upd();
		chk("lsb write", 32'h00a5_3c19, cf1);
		ser(8'h00, 32'h0000_000b, 1'b1, -1, -1);
		upd();
		ser(8'h80, 32'h0, 1'b1, -1, -1);
		chk("input only read", 32'h0000_000b, rd);
		chk("sep used", 32'h1, {31'h0, sep_seen});
		ser(8'h00, 32'h0000_0008, 1'b1, -1, -1);
		upd();
		pwr(1'b1, 8'h03, 16'hc3a5);
		pwr(1'b1, 8'h04, 16'h00e7);
		pwr(1'b0, 8'h05, 16'h00ff);
		upd();
		chk("wide write", 32'he7a5_0008, cf1);
		prd(1'b1, 8'h03);
		chk("wide read", 32'h0000_e7a5, {16'h0, pd});
		prd(1'b0, 8'h05);
		chk("unmapped read", 32'h0, {24'h0, pd[7:0]});
		dcp_host_model_i.cs_keep = 1'b1;
		ser(8'h00, 32'h0003_0008, 1'b0, -1, -1);
		ser(8'h80, 32'h0, 1'b0, -1, -1);
		dcp_host_model_i.cs_keep = 1'b0;
		chk("cs low read", 32'he7a5_0008, rd);
		upd();
		chk("cs low write", 32'h0003_0008, cf1);
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		tick(6);
		chk("rerun reset", 32'h0000_0008, cf1);
		chk("released while idle", 32'h0, {31'h0, oe_idle});
		wrap_up();
	end
endmodule
